// ==== rtl/hfc_consts.svh ====
/*
  Constants for the host-side controller that feeds and drains an external
  64x4 handshake buffer. Assumes a single 100 MHz clock and synchronous pins.
*/
// Overview of operation
// [RL1] Buffer holds 64 four-bit words, in order
// [RL2] Write and read sides run independently
// [RL3] Shift-in high with input-ready loads word
// [RL4] Drop shift-in, await input-ready low before next
// [RL5] Words ripple to output end internally
// [RL6] Output-valid rises when last position filled
// [RL7] Shift-out with output-valid releases the word
// [RL8] Drop shift-out, await output-valid low first
// [RL9] Output-valid stays low when buffer empties
// [RL10] Input-ready low while first position busy
`ifndef HFC_CONSTS_SVH
`define HFC_CONSTS_SVH
`define HFC_WORD_W 4
`define HFC_DEPTH 64
`define HFC_STAGE_W 8
`define HFC_STAGE_D 8
`define HFC_AW 3
`endif

// ==== rtl/hfc_ctrl.sv ====
/*
  Host-side controller for an external 64x4 handshake buffer. Words to be
  stored enter through a staging FIFO and are strobed into the buffer; words
  leaving the buffer are strobed out and presented on a result stream.
  Assumes buffer pins are synchronous to clock.
*/
`timescale 1ns/1ps
`include "hfc_consts.svh"
module hfc_ctrl import hfc_pkg::*; (
  input wire logic clock, // 100 MHz system clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic wr_valid, // Word to store is offered
  input wire logic [`HFC_WORD_W-1:0] wr_data, // Word to store
  output logic wr_ready, // Staging FIFO could take a word on the previous cycle (registered)
  output logic rd_valid, // Word from buffer is presented
  output logic [`HFC_WORD_W-1:0] rd_data, // Word from buffer
  input wire logic rd_ready, // User takes the word
  input wire logic input_ready, // Buffer can accept a word
  output logic shift_in, // Write strobe to buffer
  output logic [`HFC_WORD_W-1:0] write_nibble, // Write word pins
  input wire logic output_valid, // Buffer holds a word at its output
  input wire logic [`HFC_WORD_W-1:0] read_nibble, // Read word pins
  output logic shift_out // Read strobe to buffer
);
  // ----------------------------------------
  // Staging FIFO
  // ----------------------------------------
  hfc_stream_if #(.W(`HFC_WORD_W)) up_s ();
  hfc_stream_if #(.W(`HFC_WORD_W)) st_s ();
  assign up_s.valid = wr_valid;
  assign up_s.data = wr_data;
  hfc_fifo #(.W(`HFC_WORD_W), .D(`HFC_STAGE_D), .AW(`HFC_AW)) u_stage (
    .clock(clock),
    .srst(srst),
    .in_s(up_s),
    .out_s(st_s)
  );
  hfc_wst_e wst_reg;
  hfc_wst_e wst_next;
  wire load_fire = (wst_reg == HFC_W_IDLE) && st_s.valid && input_ready; // RL10
  assign st_s.ready = load_fire;
  always_ff @(posedge clock) begin
    if (srst) wr_ready <= 1'b0;
    else wr_ready <= up_s.ready;
  end

  // ----------------------------------------
  // Write handshake
  // ----------------------------------------
  always_comb begin
    case (wst_reg)
      HFC_W_IDLE: wst_next = load_fire ? HFC_W_STROBE : HFC_W_IDLE;
      HFC_W_STROBE: wst_next = input_ready ? HFC_W_STROBE : HFC_W_RELEASE; // RL3
      HFC_W_RELEASE: wst_next = input_ready ? HFC_W_RELEASE : HFC_W_IDLE; // RL4
      default: wst_next = HFC_W_IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      wst_reg <= HFC_W_IDLE;
      shift_in <= 1'b0;
      write_nibble <= '0;
    end else begin
      wst_reg <= wst_next;
      shift_in <= (wst_next == HFC_W_STROBE); // RL3
      if (load_fire) write_nibble <= st_s.data;
    end
  end

  // ----------------------------------------
  // Read handshake, independent of the write side
  // ----------------------------------------
  hfc_rst_e rst_reg;
  hfc_rst_e rst_next;
  wire out_free = !rd_valid || rd_ready;
  wire take = (rst_reg == HFC_R_WAIT) && output_valid && out_free; // RL6
  always_comb begin
    case (rst_reg)
      HFC_R_WAIT: rst_next = take ? HFC_R_STROBE : HFC_R_WAIT; // RL2
      HFC_R_STROBE: rst_next = output_valid ? HFC_R_STROBE : HFC_R_RELEASE; // RL7
      HFC_R_RELEASE: rst_next = output_valid ? HFC_R_RELEASE : HFC_R_WAIT; // RL8
      default: rst_next = HFC_R_WAIT;
    endcase
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      rst_reg <= HFC_R_WAIT;
      shift_out <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rst_reg <= rst_next;
      shift_out <= (rst_next == HFC_R_STROBE); // RL7
      if (take) begin
        rd_valid <= 1'b1; // RL1
        rd_data <= read_nibble;
      end else if (rd_ready) begin
        rd_valid <= 1'b0; // RL9
      end
    end
  end
endmodule : hfc_ctrl

// ==== rtl/hfc_fifo.sv ====
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module hfc_fifo #(
  parameter int W = 4,
  parameter int D = 8,
  parameter int AW = 3
) (
  input wire logic clock, // System clock
  input wire logic srst, // Synchronous reset
  hfc_stream_if.snk in_s, // Fill side
  hfc_stream_if.src out_s // Drain side
);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  wire full = (cnt_reg == (AW+1)'(D));
  wire empty = (cnt_reg == '0);
  wire push = in_s.valid && !full;
  wire pop = !empty && out_s.ready;
  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = mem[rd_reg];
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_reg] <= in_s.data;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
      if (pop) rd_reg <= (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : hfc_fifo

// ==== rtl/hfc_pkg.sv ====
/*
  Types for the handshake buffer controller. Assumes hfc_consts.svh.
*/
`include "hfc_consts.svh"
package hfc_pkg;
  typedef logic [`HFC_WORD_W-1:0] hfc_word_t;
  typedef enum logic [2:0] {
    HFC_W_IDLE = 3'b001,
    HFC_W_STROBE = 3'b010,
    HFC_W_RELEASE = 3'b100
  } hfc_wst_e;
  typedef enum logic [2:0] {
    HFC_R_WAIT = 3'b001,
    HFC_R_STROBE = 3'b010,
    HFC_R_RELEASE = 3'b100
  } hfc_rst_e;
endpackage : hfc_pkg

// ==== rtl/hfc_stream_if.sv ====
/*
  Valid/ready stream between the controller and its staging FIFO.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface hfc_stream_if #(parameter int W = 4);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : hfc_stream_if

// ==== sim/hfc_buf_model.sv ====
/* 64x4 handshake buffer model. Assumes pins sampled on clock. */
`timescale 1ns/1ps
module hfc_buf_model (
  input wire logic clock, // clk
  input wire logic shift_in, // in
  input wire logic [3:0] write_nibble, // in
  input wire logic shift_out, // in
  output logic input_ready, // out
  output logic output_valid = 0, // out
  output logic [3:0] read_nibble // out
);
  logic [3:0] q[$];
  logic [3:0] first, head, last = 0;
  logic held = 0, gone = 0;
  int n = 0;
  assign input_ready = !held && n < 64;
  assign read_nibble = output_valid ? head : ~last;
  always @(posedge clock) begin
    if (held && !shift_in) begin q.push_back(first); held <= 0; end
    else if (input_ready && shift_in) begin first <= write_nibble; held <= 1; end
    if (output_valid && shift_out) begin last <= head; void'(q.pop_front()); output_valid <= 0; gone <= 1; end
    else if (gone && !shift_out) gone <= 0;
    else if (!gone && q.size() > 0) output_valid <= 1;
    if (q.size() > 0) head <= q[0];
    n <= q.size();
  end
endmodule : hfc_buf_model

// ==== sim/hfc_ctrl_checker.sv ====
/* Pin handshake checks for hfc_ctrl. Assumes binding to hfc_ctrl. */
`timescale 1ns/1ps
module hfc_ctrl_checker (
  input wire logic clock, // clk
  input wire logic srst, // rst
  input wire logic rd_valid, // out
  input wire logic [3:0] rd_data, // out
  input wire logic rd_ready, // in
  input wire logic input_ready, // in
  input wire logic shift_in, // out
  input wire logic output_valid, // in
  input wire logic [3:0] read_nibble, // in
  input wire logic shift_out // out
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  a_in_start: assert property ($rose(shift_in) |-> $past(input_ready)) else $error("early write");
  a_in_hold: assert property (shift_in && input_ready |=> shift_in) else $error("write cut");
  a_in_drop: assert property (shift_in && !input_ready |=> !shift_in) else $error("write stuck");
  a_out_start: assert property ($rose(shift_out) |-> $past(output_valid)) else $error("early read");
  a_out_hold: assert property (shift_out && output_valid |=> shift_out) else $error("read cut");
  a_out_drop: assert property (shift_out && !output_valid |=> !shift_out) else $error("read stuck");
  a_rd_take: assert property ($rose(rd_valid) |-> shift_out && rd_data == $past(read_nibble))
    else $error("bad capture");
  a_rd_keep: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data)) else $error("lost");
endmodule : hfc_ctrl_checker
bind hfc_ctrl hfc_ctrl_checker chk (
  .clock(clock),
  .srst(srst),
  .rd_valid(rd_valid),
  .rd_data(rd_data),
  .rd_ready(rd_ready),
  .input_ready(input_ready),
  .shift_in(shift_in),
  .output_valid(output_valid),
  .read_nibble(read_nibble),
  .shift_out(shift_out)
);

// ==== sim/hfc_ctrl_tb.sv ====
/* Bench for hfc_ctrl against the buffer model. Assumes a 100 MHz clock. */
`timescale 1ns/1ps
module hfc_ctrl_tb;
  import hfc_pkg::*;
  logic clock = 0, srst = 1, wr_valid = 0, rd_ready = 0;
  logic wr_ready, rd_valid, shift_in, shift_out, input_ready, output_valid;
  hfc_word_t wr_data = 4'h0, rd_data, write_nibble, read_nibble;
  hfc_word_t exp_q[$];
  int bad_count = 0, checks_done = 0;
  always #5 clock = ~clock;
  hfc_ctrl dut (
    .clock(clock),
    .srst(srst),
    .wr_valid(wr_valid),
    .wr_data(wr_data),
    .wr_ready(wr_ready),
    .rd_valid(rd_valid),
    .rd_data(rd_data),
    .rd_ready(rd_ready),
    .input_ready(input_ready),
    .shift_in(shift_in),
    .write_nibble(write_nibble),
    .output_valid(output_valid),
    .read_nibble(read_nibble),
    .shift_out(shift_out)
  );
  hfc_buf_model m (
    .clock(clock),
    .shift_in(shift_in),
    .write_nibble(write_nibble),
    .shift_out(shift_out),
    .input_ready(input_ready),
    .output_valid(output_valid),
    .read_nibble(read_nibble)
  );
  task automatic chk(string what, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", what, e, s);
    end
  endtask : chk
  task automatic tick(int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : tick
  task automatic push(hfc_word_t v);
    for (int i = 0; i < 50 && wr_ready !== 1'b1; i++) tick(1);
    wr_valid = 1;
    wr_data = v;
    exp_q.push_back(v);
    tick(1);
    wr_valid = 0;
    tick(2);
  endtask : push
  always @(posedge clock) if (!srst && rd_valid === 1'b1 && rd_ready === 1'b1) chk("rd_data", exp_q.pop_front(), rd_data);
  task automatic t_stream;
    rd_ready = 1;
    for (int i = 0; i < 10; i++) push(4'(i * 7));
    tick(200);
    chk("left", 8'h00, 8'(exp_q.size()));
    chk("output_valid", 8'h00, {7'h00, output_valid});
  endtask : t_stream
  task automatic t_full;
    rd_ready = 0;
    for (int i = 0; i < 70; i++) push(4'(i * 5 + 3));
    tick(300);
    chk("stored", 8'h40, 8'(m.n));
    chk("input_ready", 8'h00, {7'h00, input_ready});
    rd_ready = 1;
    tick(700);
    chk("left", 8'h00, 8'(exp_q.size()));
  endtask : t_full
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    tick(3);
    srst = 0;
    tick(2);
    t_stream();
    t_full();
    end_sim();
  end
  initial begin
    #100000;
    bad_count++;
    end_sim();
  end
endmodule : hfc_ctrl_tb
